//--- pss_port.sv
// pss_port.sv: pipelined synchronous memory port with burst counter and sleep
// assumes: one clock; pins arrive from outside so the asynchronous burst order and sleep pins are synchronised
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.svh"

module pss_port
(
   input wire logic sys_clk_in, // 200 MHz clock
   input wire logic rst_in, // asynchronous reset, active high
   input wire logic clock_gate_n_in, // low lets the edge act
   input wire logic chip_select_a_n_in, // active-low chip select
   input wire logic chip_select_b_in, // active-high chip select
   input wire logic chip_select_c_n_in, // active-low chip select
   input wire logic advance_or_load_in, // high advance, low load
   input wire logic write_select_n_in, // low write, high read
   input wire logic [`PSS_ADDR_W-1:0] addr_in, // word address
   input wire logic [`PSS_LANES-1:0] byte_write_n_in, // per-lane write enables
   input wire logic burst_order_in, // high interleaved, low linear
   input wire logic output_enable_n_in, // asynchronous output enable
   input wire logic sleep_request_in, // asynchronous sleep request
   input wire logic [`PSS_LANE_W-1:0] data_lane_low_in, // lane a from pins
   input wire logic [`PSS_LANE_W-1:0] data_lane_high_in, // lane b from pins
   output logic [`PSS_LANE_W-1:0] data_lane_low_out, // lane a to pins
   output logic [`PSS_LANE_W-1:0] data_lane_high_out, // lane b to pins
   output logic data_oe_n_out, // low while the port drives the pins
   output logic sleeping_out // standby indication
);

   ////////////////////////////////////////////////////////////////////////////
   // asynchronous pin synchronisers: three flops, second and third must agree
   logic [2:0] order_sync;
   logic [2:0] sleep_sync;
   logic burst_order;
   logic sleep_req;

   // burst order and sleep are not timed to the clock, so they are resampled
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         order_sync <= 3'h7;
         sleep_sync <= 3'h0;
      end
      else
      begin
         order_sync <= {order_sync[1:0], burst_order_in};
         sleep_sync <= {sleep_sync[1:0], sleep_request_in};
      end
   end

   // a level counts once the last two stages agree; otherwise hold
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         burst_order <= 1'b1;
         sleep_req <= 1'b0;
      end
      else
      begin
         if (order_sync[2] == order_sync[1])
            burst_order <= order_sync[2];
         if (sleep_sync[2] == sleep_sync[1])
            sleep_req <= sleep_sync[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep entry and exit take two cycles; pending accesses are dropped
   logic [1:0] sleep_cnt;
   logic asleep;

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sleep_cnt <= 2'h0;
         asleep <= 1'b0;
      end
      else if (sleep_req != asleep)
      begin
         if (sleep_cnt == 2'(`PSS_SLEEP_CYC - 1))
         begin
            asleep <= sleep_req;
            sleep_cnt <= 2'h0;
         end
         else
            sleep_cnt <= sleep_cnt + 2'h1;
      end
      else
         sleep_cnt <= 2'h0;
   end

   assign sleeping_out = asleep;

   ////////////////////////////////////////////////////////////////////////////
   // command decode on the clock edge
   logic edge_live;
   logic selected;
   logic do_load;
   logic do_deselect;

   assign edge_live = !clock_gate_n_in && !asleep;
   assign selected = !chip_select_a_n_in && chip_select_b_in && !chip_select_c_n_in;
   assign do_load = edge_live && !advance_or_load_in && selected;
   assign do_deselect = edge_live && !advance_or_load_in && !selected;

   ////////////////////////////////////////////////////////////////////////////
   // burst state: base address, starting beat, beat counter and type
   pss_pkg::pss_burst_t burst;
   logic [`PSS_ADDR_W-1:0] base_addr;
   logic [`PSS_BEAT_W-1:0] start_beat;
   logic [`PSS_BEAT_W-1:0] beat_cnt;

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         burst <= pss_pkg::PSS_IDLE;
         base_addr <= '0;
         start_beat <= `PSS_ZERO_BEAT;
         beat_cnt <= `PSS_ZERO_BEAT;
      end
      else if (do_load)
      begin
         // address and read/write select only matter on load edges
         burst <= write_select_n_in ? pss_pkg::PSS_READ : pss_pkg::PSS_WRITE;
         base_addr <= addr_in;
         start_beat <= addr_in[`PSS_BEAT_W-1:0];
         beat_cnt <= `PSS_ONE_BEAT;
      end
      else if (do_deselect)
         burst <= pss_pkg::PSS_IDLE;
      else if (edge_live && advance_or_load_in && burst != pss_pkg::PSS_IDLE)
         beat_cnt <= beat_cnt + `PSS_ONE_BEAT; // two-bit wrap after four beats
   end

   // beat offset from the start: interleaved xors, linear adds
   logic [`PSS_BEAT_W-1:0] cur_beat;
   logic [`PSS_BEAT_W-1:0] load_beat;
   logic [`PSS_ADDR_W-1:0] access_addr;
   logic adv_beat;

   always_comb
   begin
      adv_beat = edge_live && advance_or_load_in && burst != pss_pkg::PSS_IDLE;
      load_beat = addr_in[`PSS_BEAT_W-1:0];
      if (burst_order)
         cur_beat = start_beat ^ beat_cnt;
      else
         cur_beat = start_beat + beat_cnt;
      if (do_load)
         access_addr = addr_in;
      else
         access_addr = {base_addr[`PSS_ADDR_W-1:`PSS_BEAT_W], cur_beat};
      if (do_load)
         access_addr = {addr_in[`PSS_ADDR_W-1:`PSS_BEAT_W], load_beat};
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-stage command pipeline; deselect enters an empty slot
   pss_pkg::pss_stage_t stage1;
   pss_pkg::pss_stage_t stage2;
   pss_pkg::pss_stage_t next_stage1;

   always_comb
   begin
      next_stage1 = '0;
      if (do_load || adv_beat)
      begin
         next_stage1.valid = 1'b1;
         next_stage1.write = do_load ? !write_select_n_in : (burst == pss_pkg::PSS_WRITE);
         // byte enables sampled every write beat, ignored for reads
         next_stage1.byte_write_n = next_stage1.write ? byte_write_n_in : {`PSS_LANES{1'b1}};
         next_stage1.addr = access_addr;
      end
   end

   // frozen on gated edges; sleep discards whatever is pending
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         stage1 <= '0;
         stage2 <= '0;
      end
      else if (asleep)
      begin
         stage1 <= '0;
         stage2 <= '0;
      end
      else if (!clock_gate_n_in)
      begin
         stage1 <= next_stage1;
         stage2 <= stage1; // data moves two cycles after the command
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // storage array, written and read at the second pipeline stage
   logic [`PSS_LANE_W-1:0] mem_low [0:`PSS_DEPTH-1];
   logic [`PSS_LANE_W-1:0] mem_high [0:`PSS_DEPTH-1];
   logic [`PSS_LANE_W-1:0] wr_low;
   logic [`PSS_LANE_W-1:0] wr_high;

   // write data registered on the edge it is due
   always_ff @(posedge sys_clk_in)
   begin
      if (edge_live && stage2.valid && stage2.write)
      begin
         if (!stage2.byte_write_n[0])
            mem_low[stage2.addr] <= data_lane_low_in;
         if (!stage2.byte_write_n[1])
            mem_high[stage2.addr] <= data_lane_high_in;
      end
   end

   assign wr_low = mem_low[stage2.addr];
   assign wr_high = mem_high[stage2.addr];

   // read data output register; no reset on storage-side data is harmless
   logic drive_read;

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         data_lane_low_out <= '0;
         data_lane_high_out <= '0;
         drive_read <= 1'b0;
      end
      else if (asleep)
         drive_read <= 1'b0;
      else if (!clock_gate_n_in)
      begin
         // stage2 reads land on the pins at this edge, two after the command
         // reading at stage2 sees a write from the slot before, never stale data
         drive_read <= stage2.valid && !stage2.write;
         if (stage2.valid && !stage2.write)
         begin
            data_lane_low_out <= wr_low;
            data_lane_high_out <= wr_high;
         end
      end
   end

   // output enable gates the drivers without the clock
   assign data_oe_n_out = !(drive_read && !output_enable_n_in);

endmodule // pss_port
`default_nettype wire

//--- pss_defs.svh
// pss_defs.svh: constants for the pipelined synchronous memory port
// assumes: included by bare name from the package and the design module
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

`define PSS_LANE_W 9
`define PSS_LANES 2
`define PSS_ADDR_W 19
`define PSS_DEPTH 524288
`define PSS_BEAT_W 2
`define PSS_ZERO_BEAT 2'h0
`define PSS_ONE_BEAT 2'h1
`define PSS_SLEEP_CYC 2

`endif

//--- pss_pkg.sv
// pss_pkg.sv: shared types for the pipelined synchronous memory port
// assumes: pss_defs.svh is on the include path
`include "pss_defs.svh"

package pss_pkg;

   // one access travelling down the two-stage pipeline
   typedef struct packed {
      logic valid;
      logic write;
      logic [`PSS_LANES-1:0] byte_write_n;
      logic [`PSS_ADDR_W-1:0] addr;
   } pss_stage_t;

   typedef enum logic [1:0] {
      PSS_IDLE,
      PSS_READ,
      PSS_WRITE
   } pss_burst_t;

endpackage

//--- pss_port_sva.sv
// pss_port_sva.sv: pin-level checks on the memory port
// assumes: bound to pss_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.svh"

module pss_port_sva
(
   input wire logic sys_clk_in, // clock
   input wire logic rst_in, // reset
   input wire logic clock_gate_n_in, // gate
   input wire logic chip_select_a_n_in, // select
   input wire logic chip_select_b_in, // select
   input wire logic chip_select_c_n_in, // select
   input wire logic advance_or_load_in, // adv/load
   input wire logic write_select_n_in, // rw
   input wire logic output_enable_n_in, // oe
   input wire logic sleep_request_in, // sleep
   input wire logic [`PSS_LANE_W-1:0] data_lane_low_out, // lane a
   input wire logic [`PSS_LANE_W-1:0] data_lane_high_out, // lane b
   input wire logic data_oe_n_out, // drive
   input wire logic sleeping_out // standby
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   logic sel;
   logic go;
   // decode; go is false while asleep or requesting sleep, since sleep drops pending beats
   assign sel = !chip_select_a_n_in && chip_select_b_in && !chip_select_c_n_in;
   assign go = !clock_gate_n_in && !sleeping_out && !sleep_request_in;
   ////////////////////////////////////////////////////////////////////////////////
   AST_OE_HIGH: assert property (output_enable_n_in |-> data_oe_n_out)
      else $error("pins driven with oe high");
   AST_DESEL_IDLE: assert property (go && !advance_or_load_in && !sel ##1 go [*2] |=> data_oe_n_out)
      else $error("pins driven after deselect");
   AST_WRITE_IDLE: assert property (go && !advance_or_load_in && sel && !write_select_n_in ##1 go [*2] |=> data_oe_n_out)
      else $error("pins driven on a write slot");
   AST_READ_DRIVE: assert property (go && !advance_or_load_in && sel && write_select_n_in ##1 go [*2] |=> output_enable_n_in || !data_oe_n_out)
      else $error("read beat missing");
   AST_ADV_READ: assert property (go && !advance_or_load_in && sel && write_select_n_in ##1 go && advance_or_load_in ##1 go [*2] |=> output_enable_n_in || !data_oe_n_out)
      else $error("burst beat missing");
   AST_ADV_DEAD: assert property (go && !advance_or_load_in && !sel ##1 go && advance_or_load_in ##1 go [*2] |=> data_oe_n_out)
      else $error("advance after deselect drove");
   AST_GATE_HOLD: assert property (clock_gate_n_in |=> $stable(data_lane_low_out) && $stable(data_lane_high_out))
      else $error("outputs moved on gated edge");
   AST_SLEEP_IN: assert property ((sleep_request_in && !clock_gate_n_in) [*8] |-> sleeping_out)
      else $error("standby not entered");
   AST_SLEEP_OUT: assert property ((!sleep_request_in && !clock_gate_n_in) [*8] |-> !sleeping_out)
      else $error("standby not left");
endmodule // pss_port_sva

bind pss_port pss_port_sva pss_port_sva_inst (.*);
`default_nettype wire

//--- pss_ctrl_model.sv
// pss_ctrl_model.sv: controller side of the data lanes
// assumes: the bench flags each write beat when it drives the command
`timescale 1ns/1ps
`default_nettype none

module pss_ctrl_model
(
   input wire logic clk_in, // clock
   input wire logic wr_in, // write beat issued
   input wire logic [17:0] wdata_in, // its data
   output logic [17:0] data_out // lanes to port
);
   logic stage_v = 1'h0;
   logic [17:0] stage_d = 18'h0;
   // data lands for the second edge after the command; off a write the lanes
   // toggle so a word one edge stale never passes for fresh data
   initial data_out = 18'h0;
   always @(posedge clk_in)
   begin
      stage_v <= wr_in;
      stage_d <= wdata_in;
      data_out <= stage_v ? stage_d : ~data_out;
   end
endmodule // pss_ctrl_model
`default_nettype wire

//--- pss_port_bench.sv
// pss_port_bench.sv: self-checking bench for the memory port
// assumes: pss_port, pss_ctrl_model and the checker compiled before it
`timescale 1ns/1ps
`default_nettype none

module pss_port_bench;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic gate_n = 1'h0;
   logic [2:0] cs = 3'h2;
   logic adv = 1'h1;
   logic wr_n = 1'h1;
   logic [18:0] addr = 19'h0;
   logic [1:0] bw = 2'h3;
   logic order = 1'h1;
   logic oe_n = 1'h0;
   logic sleep = 1'h0;
   logic mw = 1'h0;
   logic [17:0] md = 18'h0;
   logic [17:0] din;
   logic [8:0] qlo;
   logic [8:0] qhi;
   logic doe_n;
   logic slp;
   logic [17:0] mem [int];
   logic [18:0] q [$];
   logic on = 1'h0;
   logic pg = 1'h1;
   logic bwr;
   logic [18:0] ba;
   logic [1:0] bk;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;

   pss_port pss_port_inst (.sys_clk_in(clk), .rst_in(rst), .clock_gate_n_in(gate_n),
      .chip_select_a_n_in(cs[2]), .chip_select_b_in(cs[1]), .chip_select_c_n_in(cs[0]),
      .advance_or_load_in(adv), .write_select_n_in(wr_n), .addr_in(addr),
      .byte_write_n_in(bw), .burst_order_in(order), .output_enable_n_in(oe_n),
      .sleep_request_in(sleep), .data_lane_low_in(din[8:0]), .data_lane_high_in(din[17:9]),
      .data_lane_low_out(qlo), .data_lane_high_out(qhi), .data_oe_n_out(doe_n),
      .sleeping_out(slp));
   pss_ctrl_model pss_ctrl_model_inst (.clk_in(clk), .wr_in(mw), .wdata_in(md), .data_out(din));

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   // hang guard, well above the ~1250 cycles the run needs
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fail_count = fail_count + 1;
         report_and_stop();
      end
   end

   function automatic logic [1:0] beat(input logic [1:0] s, input logic [1:0] k);
      return order ? s ^ k : s + k;
   endfunction

   task automatic check(input logic [18:0] got, input logic [18:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one edge: drive pins, check the beat issued two acting edges ago
   task automatic step(input logic g, input logic [2:0] c, input logic a, input logic w,
      input logic [18:0] ad, input logic [1:0] b, input logic o);
      logic [18:0] e;
      logic [18:0] x;
      logic [17:0] d;
      int i;
      @(posedge clk);
      gate_n <= g;
      cs <= c;
      adv <= a;
      wr_n <= w;
      addr <= ad;
      bw <= b;
      oe_n <= o;
      d = 18'($urandom);
      x = 19'h0;
      if (!g)
      begin
         if (!a)
         begin
            on = c == 3'h2;
            bwr = !w;
            ba = ad;
            bk = 2'h0;
         end
         else
            bk = bk + 2'h1;
         i = {ba[18:2], beat(ba[1:0], bk)};
         if (on && bwr)
         begin
            md <= d;
            if (!b[0]) mem[i][8:0] = d[8:0];
            if (!b[1]) mem[i][17:9] = d[17:9];
         end
         else if (on)
            x = {1'h1, mem[i]};
      end
      // one assignment per edge: write beat flag for the data model
      mw <= !g && on && bwr;
      #1;
      if (!pg && q.size() == 3)
      begin
         e = q.pop_front();
         check({!doe_n, doe_n ? 18'h0 : {qhi, qlo}}, e[18] && !o ? e : 19'h0);
      end
      pg = g;
      if (!g)
         q.push_back(x);
   endtask

   task automatic burst_set(input int n);
      logic [18:0] a;
      logic [2:0] c;
      a = 19'($urandom);
      c = n % 3 == 0 ? 3'h6 : n % 3 == 1 ? 3'h0 : 3'h3;
      // full fill, then a byte-masked rewrite; advances carry junk address and rw
      for (int k = 0; k < 8; k++)
         step(1'h0, 3'h2, k % 4 != 0, k % 4 != 0 && 1'($urandom), k % 4 ? 19'($urandom) : a,
            k < 4 ? 2'h0 : 2'($urandom), 1'($urandom));
      // read back: wraps past four beats, or is cut by a deselect
      for (int k = 0; k < 7; k++)
         step(k > 1 && $urandom % 6 == 0, k == 4 && n % 2 ? c : 3'h2,
            !(k == 0 || (k == 4 && n % 2)), k ? 1'($urandom) : 1'h1,
            k ? 19'($urandom) : a, 2'($urandom), $urandom % 4 == 0);
   endtask

   task automatic report_and_stop();
      if (fail_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      void'($urandom(82293));
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      for (int p = 0; p < 2; p++)
      begin
         for (int n = 0; n < 40; n++)
            burst_set(n);
         // order only changes under reset, never in operation
         rst <= 1'h1;
         order <= 1'h0;
         repeat (4) @(posedge clk);
         rst <= 1'h0;
         // let the order level pass the three-flop synchroniser first
         repeat (4) @(posedge clk);
         q.delete();
         on = 1'h0;
         pg = 1'h1;
      end
      for (int k = 0; k < 4; k++)
         step(1'h0, 3'h0, 1'h0, 1'h1, 19'h0, 2'h3, 1'h0);
      sleep <= 1'h1;
      repeat (12) @(posedge clk);
      #1;
      check({18'h0, slp}, 19'h1);
      sleep <= 1'h0;
      repeat (12) @(posedge clk);
      #1;
      check({18'h0, slp}, 19'h0);
      report_and_stop();
   end
endmodule // pss_port_bench
`default_nettype wire
